// ==== verilog/iqpr_defines.vh ====
// constants for the interrupt queue priority router
`ifndef IQPR_DEFINES_VH
`define IQPR_DEFINES_VH
`define IQPR_ADDR_W          8
`define IQPR_OFS_STAGE_MASK  8'h00
`define IQPR_OFS_COMMIT_CTRL 8'h04
`define IQPR_OFS_MASK_READ   8'h08
`define IQPR_OFS_IRQ_STATUS  8'h0C
`define IQPR_OFS_IRQ_MASK    8'h10
`define IQPR_QSEL_LSB        0
`define IQPR_QSEL_MSB        2
`define IQPR_STROBE_BIT      8
`define IQPR_HIPRI_QUEUE     3'h7
`define IQPR_LAST_MASKED_Q   3'h6
`define IQPR_MASK_RESET      32'h00000000
`define IQPR_IRQ_MASK_RESET  2'h3
`define IQPR_EV_REGULAR      0
`define IQPR_EV_HIPRI        1
`endif

// ==== verilog/iqpr_router.v ====
// interrupt queue priority router: steers channel vectors to regular or high-priority queue
`timescale 1ns/100ps
`default_nettype none
`include "iqpr_defines.vh"
//
// Overview of operation
// - each vector normally goes to the regular queue of its channel, 0 to 7
// - queue 7 is the fixed high-priority queue, never configurable
// - queues 0 to 6 each have their own high-priority mask over vector bits; queue 7 mask stays zero
// - software stages a mask, then selects queue and strobes to commit it
// - vector with any set bit also masked goes to the high-priority queue
// - vector with only unmasked set bits goes to its regular queue
module iqpr_router (
    input  wire        clk_sys_i,
    input  wire        arst_n_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    input  wire        vec_valid_i,
    input  wire [31:0] vec_data_i,
    input  wire [2:0]  vec_queue_i,
    output reg         out_valid_o,
    output reg  [31:0] out_data_o,
    output reg  [2:0]  out_queue_o,
    output reg         out_hipri_o,
    output wire        irq_o
);

    // =========================================================
    // register state
    reg [31:0] stage_mask_r;
    reg [2:0]  queue_sel_r;
    reg [31:0] hp_mask_r [0:7];
    reg [1:0]  irq_status_r;
    reg [1:0]  irq_status_nxt;
    reg [1:0]  irq_mask_r;
    reg [31:0] rdata_nxt;
    wire       commit;
    wire       forward;
    wire       status_rd;

    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // =========================================================
    // staging and commit
    assign commit = reg_wr_i && hit(reg_addr_i, `IQPR_OFS_COMMIT_CTRL)
                    && reg_wdata_i[`IQPR_STROBE_BIT];
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage_mask_r <= `IQPR_MASK_RESET;
            queue_sel_r  <= 3'h0;
            irq_mask_r   <= `IQPR_IRQ_MASK_RESET;
        end else if (reg_wr_i) begin
            if (hit(reg_addr_i, `IQPR_OFS_STAGE_MASK)) begin
                stage_mask_r <= reg_wdata_i;
            end
            if (hit(reg_addr_i, `IQPR_OFS_COMMIT_CTRL)) begin
                queue_sel_r <= reg_wdata_i[`IQPR_QSEL_MSB:`IQPR_QSEL_LSB];
            end
            if (hit(reg_addr_i, `IQPR_OFS_IRQ_MASK)) begin
                irq_mask_r <= reg_wdata_i[1:0];
            end
        end
    end

    // one mask per queue; queue 7 mask is never written
    genvar gq;
    generate
        for (gq = 0; gq < 8; gq = gq + 1) begin : g_mask
            always @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    hp_mask_r[gq] <= `IQPR_MASK_RESET;
                end else if (commit && (gq <= `IQPR_LAST_MASKED_Q)
                             && (reg_wdata_i[`IQPR_QSEL_MSB:`IQPR_QSEL_LSB] == gq)) begin
                    hp_mask_r[gq] <= stage_mask_r;
                end
            end
        end
    endgenerate

    // =========================================================
    // routing
    assign forward = |(vec_data_i & hp_mask_r[vec_queue_i]);
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= 32'h00000000;
            out_queue_o <= 3'h0;
            out_hipri_o <= 1'b0;
        end else begin
            out_valid_o <= vec_valid_i;
            if (vec_valid_i) begin
                out_data_o  <= vec_data_i;
                out_hipri_o <= forward;
                out_queue_o <= forward ? `IQPR_HIPRI_QUEUE : vec_queue_i;
            end
        end
    end

    // =========================================================
    // interrupt status, cleared on read, set wins
    assign status_rd = reg_rd_i && hit(reg_addr_i, `IQPR_OFS_IRQ_STATUS);
    always @* begin
        irq_status_nxt = status_rd ? 2'h0 : irq_status_r;
        if (vec_valid_i && !forward) begin
            irq_status_nxt[`IQPR_EV_REGULAR] = 1'b1;
        end
        if (vec_valid_i && forward) begin
            irq_status_nxt[`IQPR_EV_HIPRI] = 1'b1;
        end
    end
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_status_r <= 2'h0;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end
    assign irq_o = |(irq_status_r & ~irq_mask_r);

    // =========================================================
    // read path
    always @* begin
        rdata_nxt = 32'h00000000;
        case (reg_addr_i)
            `IQPR_OFS_STAGE_MASK:  rdata_nxt = stage_mask_r;
            `IQPR_OFS_COMMIT_CTRL: rdata_nxt = {29'h00000000, queue_sel_r};
            `IQPR_OFS_MASK_READ:   rdata_nxt = hp_mask_r[queue_sel_r];
            `IQPR_OFS_IRQ_STATUS:  rdata_nxt = {30'h00000000, irq_status_r};
            `IQPR_OFS_IRQ_MASK:    rdata_nxt = {30'h00000000, irq_mask_r};
            default:               rdata_nxt = 32'h00000000;
        endcase
    end
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// ==== verif/iqpr_props.sv ====
// assertions on the router vector path
`timescale 1ns/100ps
`default_nettype none
module iqpr_props (
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    input wire logic        vec_valid_i,
    input wire logic [31:0] vec_data_i,
    input wire logic [2:0]  vec_queue_i,
    input wire logic        out_valid_o,
    input wire logic [31:0] out_data_o,
    input wire logic [2:0]  out_queue_o,
    input wire logic        out_hipri_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    one_out_a: assert property (vec_valid_i |=> out_valid_o) else $error("lost");
    no_extra_a: assert property (!vec_valid_i |=> !out_valid_o) else $error("extra");
    data_copy_a: assert property (vec_valid_i |=> out_data_o == $past(vec_data_i)) else $error("data");
    hipri_q7_a: assert property (out_valid_o && out_hipri_o |-> out_queue_o == 3'h7) else $error("hp");
    own_queue_a: assert property (vec_valid_i ##1 !out_hipri_o |-> out_queue_o == $past(vec_queue_i))
        else $error("queue");
    q7_fixed_a: assert property (vec_valid_i && vec_queue_i == 3'h7 |=> out_queue_o == 3'h7) else $error("q7");
    no_bits_a: assert property (vec_valid_i && vec_data_i == 32'h0 |=> !out_hipri_o) else $error("zero");
    cover property (out_valid_o && out_hipri_o);
    cover property (out_valid_o && !out_hipri_o);
    cover property (vec_valid_i && vec_queue_i == 3'h7);
endmodule
bind iqpr_router iqpr_props props_u (.clk_sys_i, .arst_n_i, .vec_valid_i, .vec_data_i, .vec_queue_i,
    .out_valid_o, .out_data_o, .out_queue_o, .out_hipri_o);
`default_nettype wire

// ==== verif/iqpr_vec_src.sv ====
// channel vector source model
`timescale 1ns/100ps
`default_nettype none
module iqpr_vec_src (
    input  wire logic        clk_i,
    output var  logic        valid_o = 1'b0,
    output var  logic [31:0] data_o = 32'h0,
    output var  logic [2:0]  queue_o = 3'h0
);
    task automatic send(input logic [31:0] d, input logic [2:0] q);
        @(posedge clk_i);
        valid_o <= 1'b1;
        data_o <= d;
        queue_o <= q;
        @(posedge clk_i);
        valid_o <= 1'b0;
        data_o <= ~d;
    endtask
endmodule
`default_nettype wire

// ==== verif/iqpr_router_tb_top.sv ====
// self-checking bench for the queue router
`timescale 1ns/100ps
`default_nettype none
module iqpr_router_tb_top;
    logic        clk_sys_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    wire  [31:0] reg_rdata_o, vec_data_i, out_data_o;
    wire  [2:0]  vec_queue_i, out_queue_o;
    wire         vec_valid_i, out_valid_o, out_hipri_o, irq_o;
    int          err_count = 0;
    int          n_tests = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    iqpr_router dut_u (.clk_sys_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .vec_valid_i, .vec_data_i, .vec_queue_i, .out_valid_o, .out_data_o, .out_queue_o, .out_hipri_o, .irq_o);
    iqpr_vec_src src_u (.clk_i(clk_sys_i), .valid_o(vec_valid_i), .data_o(vec_data_i), .queue_o(vec_queue_i));
    task automatic chk(input logic [36:0] got, input logic [36:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1 if (!w) chk({5'h0, reg_rdata_o}, {5'h0, d});
    endtask
    task automatic vec(input logic [31:0] d, input logic [2:0] q, input logic [2:0] eq);
        src_u.send(d, q);
        #1 chk({out_valid_o, out_hipri_o, out_queue_o, out_data_o}, {1'b1, eq != q, eq, d});
    endtask
    task automatic t_commit;
        bus(1'b0, 8'h10, 32'h3);
        bus(1'b1, 8'h00, 32'hF0);
        bus(1'b1, 8'h04, 32'h103);
        bus(1'b0, 8'h08, 32'hF0);
        bus(1'b1, 8'h04, 32'h107);
        bus(1'b0, 8'h08, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
    endtask
    task automatic t_route;
        vec(32'h10, 3'h3, 3'h7);
        vec(32'h1, 3'h3, 3'h3);
        vec(32'h11, 3'h3, 3'h7);
        vec(32'h0, 3'h3, 3'h3);
        vec(32'h10, 3'h2, 3'h2);
        vec(32'hFFFFFFFF, 3'h7, 3'h7);
    endtask
    task automatic t_irq;
        bus(1'b0, 8'h0C, 32'h3);
        bus(1'b1, 8'h10, 32'h1);
        vec(32'h1, 3'h3, 3'h3);
        chk({36'h0, irq_o}, 37'h0);
        vec(32'h10, 3'h3, 3'h7);
        chk({36'h0, irq_o}, 37'h1);
        bus(1'b0, 8'h0C, 32'h3);
        chk({36'h0, irq_o}, 37'h0);
    endtask
    task automatic results;
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        results;
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_commit;
        t_route;
        t_irq;
        results;
    end
endmodule
`default_nettype wire
